// ---- hw/pwrseq_pkg.sv ----
// Shared types and constants of the power-state sequencer
package pwrseq_pkg;

    // Power states, exactly five
    typedef enum logic [2:0] {
        ST_G3 = 3'h0,
        ST_S5OFF = 3'h1,
        ST_S5ON = 3'h2,
        ST_S0 = 3'h3,
        ST_S3 = 3'h4
    } pstate_t;

    // Rail gate drivers
    typedef struct packed {
        logic dual5_standby_gate;
        logic dual3_standby_gate;
        logic dual5_main_gate;
        logic dual3_main_gate;
        logic mem_rail;
        logic term_rail;
    } rails_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } avs_req_t;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } avs_rsp_t;

    // Register byte offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h8;

    // Interrupt status bits
    localparam int IRQ_STATE = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_RAMP = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // Status register fields
    localparam int STAT_STATE = 0;
    localparam int STAT_RAMP = 3;
    localparam int STAT_TGT = 4;
    localparam int STAT_FAULT = 7;
    localparam int STAT_ARM = 8;
    localparam int STAT_IN = 16;

    // Synchronised input vector layout
    localparam int IN_SLEEP = 0;
    localparam int IN_SOFTOFF = 1;
    localparam int IN_KEEP = 2;
    localparam int IN_PG = 3;
    localparam int IN_UV = 4;
    localparam int IN_SS = 5;
    localparam int IN_SB = 6;
    localparam int IN_W = 7;
    // Request pins idle high as if pulled up
    localparam logic [6:0] IN_RST = 7'h07;

endpackage : pwrseq_pkg

// ---- hw/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] q;
    } sync_t;

    sync_t r;
    sync_t next_r;

    // First stage feeds only the second; output moves when 2 and 3 agree
    always_comb begin
        next_r = r;
        next_r.ff1 = i_pin;
        next_r.ff2 = r.ff1;
        next_r.ff3 = r.ff2;
        for (int i = 0; i < W; i++) begin
            if (r.ff2[i] == r.ff3[i]) begin
                next_r.q[i] = r.ff3[i];
            end
        end
    end

    // Reset loads the idle level of every pin
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            r <= {RST, RST, RST, RST};
        end else begin
            r <= next_r;
        end
    end

    assign o_q = r.q;

endmodule : pin_sync

// ---- hw/pwrseq_core.sv ----
// Suspend-to-RAM power-state sequencer with Avalon-MM registers
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps

module pwrseq_core (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_sleep_req_n,
    input wire logic i_softoff_req_n,
    input wire logic i_dual5_keep_en_n,
    input wire logic i_power_good,
    input wire logic i_standby_ok,
    input wire logic i_ss_at_limit,
    input wire logic i_mem_undervolt,
    input wire pwrseq_pkg::avs_req_t i_avs,
    output pwrseq_pkg::avs_rsp_t o_avs,
    output pwrseq_pkg::rails_t o_rails,
    output logic o_power_good,
    output logic o_power_good_oe,
    output logic o_uv_arm,
    output logic o_ss_run,
    output logic o_irq
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        pwrseq_pkg::pstate_t st;
        logic ramp;
        pwrseq_pkg::pstate_t tgt;
        logic seen_low;
        logic fault;
        pwrseq_pkg::rails_t rails;
        logic uv_arm;
        logic pg_oe;
        logic [pwrseq_pkg::IRQ_W-1:0] istat;
        logic [pwrseq_pkg::IRQ_W-1:0] imask;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
    } core_t;

    core_t r;
    core_t next_r;
    logic [pwrseq_pkg::IN_W-1:0] in_q;
    logic sleep;
    logic softoff;
    logic keep;
    logic pg;
    logic uv;
    logic ss;
    logic sb;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    // Pins pass three stages; pull-up idle level loaded at reset
    pin_sync #(
        .W(pwrseq_pkg::IN_W),
        .RST(pwrseq_pkg::IN_RST)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_pin({i_standby_ok, i_ss_at_limit, i_mem_undervolt,
                i_power_good, i_dual5_keep_en_n, i_softoff_req_n,
                i_sleep_req_n}),
        .o_q(in_q)
    );

    // Named views of the synchronised pins
    assign sleep = in_q[pwrseq_pkg::IN_SLEEP];
    assign softoff = in_q[pwrseq_pkg::IN_SOFTOFF];
    assign keep = in_q[pwrseq_pkg::IN_KEEP];
    assign pg = in_q[pwrseq_pkg::IN_PG];
    assign uv = in_q[pwrseq_pkg::IN_UV];
    assign ss = in_q[pwrseq_pkg::IN_SS];
    assign sb = in_q[pwrseq_pkg::IN_SB];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Rail gates of a state plus those being soft-ramped
    function automatic pwrseq_pkg::rails_t rails_of(
        input pwrseq_pkg::pstate_t st,
        input logic ramp,
        input pwrseq_pkg::pstate_t tgt
    );
        pwrseq_pkg::rails_t v;
        v = '0;
        case (st)
            pwrseq_pkg::ST_S5OFF: begin
                v.dual3_standby_gate = 1'b1;
            end
            pwrseq_pkg::ST_S5ON: begin
                v.dual3_standby_gate = 1'b1;
                v.dual5_standby_gate = 1'b1;
            end
            pwrseq_pkg::ST_S0: begin
                v.dual5_main_gate = 1'b1;
                v.dual3_main_gate = 1'b1;
                v.mem_rail = 1'b1;
                v.term_rail = 1'b1;
            end
            pwrseq_pkg::ST_S3: begin
                v.dual5_standby_gate = 1'b1;
                v.dual3_standby_gate = 1'b1;
                v.mem_rail = 1'b1;
                v.term_rail = 1'b1;
            end
            default: begin
                v = '0;
            end
        endcase
        // Ramped rails switch on while the ramp clamps their slew
        if (ramp && tgt == pwrseq_pkg::ST_S5ON) begin
            v.dual5_standby_gate = 1'b1;
        end
        if (ramp && tgt == pwrseq_pkg::ST_S0) begin
            v.mem_rail = 1'b1;
            v.term_rail = 1'b1;
        end
        return v;
    endfunction : rails_of

    // S5 substate chosen from the keep-enable level
    function automatic pwrseq_pkg::pstate_t pick_s5(input logic k);
        return k ? pwrseq_pkg::ST_S5OFF : pwrseq_pkg::ST_S5ON;
    endfunction : pick_s5

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Sequencer, fault, interrupt and bus slave in one pass
    always_comb begin
        logic req;
        logic take;
        logic [pwrseq_pkg::IRQ_W-1:0] ev;
        logic [pwrseq_pkg::IRQ_W-1:0] clr;
        req = 1'b0;
        take = 1'b0;
        ev = '0;
        clr = '0;
        next_r = r;
        if (!sb) begin
            // Loss of standby supply falls back to G3
            next_r.st = pwrseq_pkg::ST_G3;
            next_r.ramp = 1'b0;
        end else if (r.ramp) begin
            next_r.seen_low = r.seen_low | ~ss;
            if (r.tgt == pwrseq_pkg::ST_S5ON && keep) begin
                next_r.ramp = 1'b0;
            end else if (r.tgt == pwrseq_pkg::ST_S0 && !softoff) begin
                next_r.ramp = 1'b0;
                next_r.st = pick_s5(keep);
            end else if (r.seen_low && ss) begin
                next_r.st = r.tgt;
                next_r.ramp = 1'b0;
                ev[pwrseq_pkg::IRQ_RAMP] = 1'b1;
            end
        end else begin
            case (r.st)
                pwrseq_pkg::ST_G3: begin
                    next_r.st = pwrseq_pkg::ST_S5OFF;
                end
                pwrseq_pkg::ST_S5OFF: begin
                    if (!keep && !softoff) begin
                        next_r.ramp = 1'b1;
                        next_r.tgt = pwrseq_pkg::ST_S5ON;
                        next_r.seen_low = 1'b0;
                    end else if (sleep && softoff) begin
                        next_r.ramp = 1'b1;
                        next_r.tgt = pwrseq_pkg::ST_S0;
                        next_r.seen_low = 1'b0;
                    end
                end
                pwrseq_pkg::ST_S5ON: begin
                    if (keep) begin
                        next_r.st = pwrseq_pkg::ST_S5OFF;
                    end else if (sleep && softoff) begin
                        next_r.ramp = 1'b1;
                        next_r.tgt = pwrseq_pkg::ST_S0;
                        next_r.seen_low = 1'b0;
                    end
                end
                pwrseq_pkg::ST_S0: begin
                    if (!softoff) begin
                        next_r.st = pick_s5(keep);
                    end else if (!sleep) begin
                        next_r.st = pwrseq_pkg::ST_S3;
                    end
                end
                pwrseq_pkg::ST_S3: begin
                    if (!softoff) begin
                        next_r.st = pick_s5(keep);
                    end else if (sleep && pg) begin
                        next_r.st = pwrseq_pkg::ST_S0;
                    end
                end
                default: begin
                    next_r.st = pwrseq_pkg::ST_G3;
                end
            endcase
        end
        if (next_r.st != r.st) begin
            ev[pwrseq_pkg::IRQ_STATE] = 1'b1;
        end

        // Outputs follow the new state
        next_r.rails = rails_of(next_r.st, next_r.ramp, next_r.tgt);
        next_r.uv_arm = (next_r.st == pwrseq_pkg::ST_S0)
            || (next_r.st == pwrseq_pkg::ST_S3);

        // Under-voltage fault, dropped when monitor disarms
        if (!next_r.uv_arm) begin
            next_r.fault = 1'b0;
        end else if (r.uv_arm && uv) begin
            next_r.fault = 1'b1;
            if (!r.fault) begin
                ev[pwrseq_pkg::IRQ_FAULT] = 1'b1;
            end
        end
        next_r.pg_oe = next_r.fault;

        // Bus slave: one wait cycle, then completion
        req = i_avs.read | i_avs.write;
        take = req & ~r.waitreq;
        next_r.waitreq = ~(req & r.waitreq);
        if (req && r.waitreq && i_avs.read) begin
            case (i_avs.address)
                pwrseq_pkg::REG_STATUS: begin
                    next_r.rdata = '0;
                    next_r.rdata[pwrseq_pkg::STAT_STATE +: 3] = r.st;
                    next_r.rdata[pwrseq_pkg::STAT_RAMP] = r.ramp;
                    next_r.rdata[pwrseq_pkg::STAT_TGT +: 3] = r.tgt;
                    next_r.rdata[pwrseq_pkg::STAT_FAULT] = r.fault;
                    next_r.rdata[pwrseq_pkg::STAT_ARM] = r.uv_arm;
                    next_r.rdata[pwrseq_pkg::STAT_IN +: pwrseq_pkg::IN_W]
                        = in_q;
                end
                pwrseq_pkg::REG_IRQ_STAT: begin
                    next_r.rdata = {29'h0, r.istat};
                end
                pwrseq_pkg::REG_IRQ_MASK: begin
                    next_r.rdata = {29'h0, r.imask};
                end
                default: begin
                    next_r.rdata = '0;
                end
            endcase
        end
        if (take && i_avs.write) begin
            if (i_avs.address == pwrseq_pkg::REG_IRQ_STAT) begin
                clr = i_avs.writedata[pwrseq_pkg::IRQ_W-1:0];
            end
            if (i_avs.address == pwrseq_pkg::REG_IRQ_MASK) begin
                next_r.imask = i_avs.writedata[pwrseq_pkg::IRQ_W-1:0];
            end
        end

        // Sticky status: a new event beats a same-cycle clear
        next_r.istat = (r.istat & ~clr) | ev;
        next_r.irq = |(next_r.istat & next_r.imask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset to G3 with all rails off and the bus stalled
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            r <= '0;
            r.st <= pwrseq_pkg::ST_G3;
            r.tgt <= pwrseq_pkg::ST_G3;
            r.imask <= pwrseq_pkg::IRQ_MASK_RST;
            r.waitreq <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Output drive straight from the state record, except power good data tied low
    assign o_rails = r.rails;
    assign o_uv_arm = r.uv_arm;
    assign o_ss_run = r.ramp;
    assign o_power_good = 1'b0; // Open collector only ever pulls low
    assign o_power_good_oe = r.pg_oe;
    assign o_irq = r.irq;
    assign o_avs.waitrequest = r.waitreq;
    assign o_avs.readdata = r.rdata;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_G3_LEAVE: assert property (@(posedge i_mclk) disable iff (i_srst)
        r.st == pwrseq_pkg::ST_G3 && sb |=> r.st == pwrseq_pkg::ST_S5OFF)
        else $error("G3 did not move to S5 off");

    AST_D5_RAMP: assert property (@(posedge i_mclk) disable iff (i_srst)
        r.st == pwrseq_pkg::ST_S5OFF && !r.ramp && sb && !keep && !softoff
        |=> r.ramp && r.tgt == pwrseq_pkg::ST_S5ON && o_ss_run
            && o_rails.dual5_standby_gate)
        else $error("S5 rail-on ramp not started");

    AST_S0_RAMP: assert property (@(posedge i_mclk) disable iff (i_srst)
        r.st == pwrseq_pkg::ST_S5OFF && !r.ramp && sb && sleep && softoff
        |=> r.ramp && r.tgt == pwrseq_pkg::ST_S0 && o_rails.mem_rail)
        else $error("S0 ramp not started");

    AST_D5_OFF: assert property (@(posedge i_mclk) disable iff (i_srst)
        r.st == pwrseq_pkg::ST_S5ON && !r.ramp && sb && keep
        |=> r.st == pwrseq_pkg::ST_S5OFF && !o_rails.dual5_standby_gate)
        else $error("S5 rail-on did not drop");

    AST_S0_SLEEP: assert property (@(posedge i_mclk) disable iff (i_srst)
        r.st == pwrseq_pkg::ST_S0 && sb && softoff && !sleep
        |=> r.st == pwrseq_pkg::ST_S3)
        else $error("S0 did not enter S3");

    AST_S3_WAIT: assert property (@(posedge i_mclk) disable iff (i_srst)
        r.st == pwrseq_pkg::ST_S3 && sb && softoff && !pg
        |=> r.st == pwrseq_pkg::ST_S3)
        else $error("S3 left without power good");

    AST_S0_RAILS: assert property (@(posedge i_mclk) disable iff (i_srst)
        r.st == pwrseq_pkg::ST_S0 |-> o_rails == 6'h0f && o_uv_arm)
        else $error("S0 rail set wrong");

    AST_ARM_OFF: assert property (@(posedge i_mclk) disable iff (i_srst)
        $rose(o_uv_arm) |-> $past(sb) && (r.st == pwrseq_pkg::ST_S0
            || r.st == pwrseq_pkg::ST_S3))
        else $error("Monitor armed outside S0 or S3");

    AST_UV_PULL: assert property (@(posedge i_mclk) disable iff (i_srst)
        o_uv_arm && uv && sb && softoff && !(r.st == pwrseq_pkg::ST_S0
            && !sleep) |=> o_power_good_oe && !o_power_good)
        else $error("Fault did not pull power good");

    AST_RAMP_HOLD: assert property (@(posedge i_mclk) disable iff (i_srst)
        r.ramp && sb && !ss
        && (r.tgt == pwrseq_pkg::ST_S0 ? softoff : !keep)
        |=> r.ramp && $stable(r.st))
        else $error("Ramp ended before limit");

endmodule : pwrseq_core

// ---- bench/pmc_model.sv ----
// Chipset power-management model: request pins and power-good wire
`timescale 1ns/1ps

module pmc_model (
    input wire logic i_mclk,
    input wire logic i_float,
    input wire logic i_sleep_n,
    input wire logic i_off_n,
    input wire logic i_keep_n,
    input wire logic i_sys_pg,
    input wire logic i_dev_pull,
    output logic o_sleep_req_n,
    output logic o_softoff_req_n,
    output logic o_dual5_keep_en_n,
    output logic o_power_good
);
    // Pins change just after an edge; an undriven pin reads high
    always @(posedge i_mclk) begin
        o_sleep_req_n <= i_float | i_sleep_n;
        o_softoff_req_n <= i_float | i_off_n;
        o_dual5_keep_en_n <= i_float | i_keep_n;
    end

    // Open-collector wire: either side may pull it low
    assign o_power_good = i_sys_pg & ~i_dev_pull;
endmodule : pmc_model

// ---- bench/pwrseq_core_bench.sv ----
// Self-checking bench of the power-state sequencer
`timescale 1ns/1ps

module pwrseq_core_bench;
    // Expected rail sets, MSB first as in the rail struct
    localparam logic [5:0] R_G3 = 6'h00;
    localparam logic [5:0] R_S5OFF = 6'h10;
    localparam logic [5:0] R_S5ON = 6'h30;
    localparam logic [5:0] R_S0 = 6'h0f;
    localparam logic [5:0] R_S3 = 6'h33;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic standby_ok = 1'b0;
    logic ss_at_limit = 1'b0;
    logic mem_undervolt = 1'b0;
    logic pin_float = 1'b1;
    logic sleep_n = 1'b0;
    logic off_n = 1'b0;
    logic keep_n = 1'b0;
    logic sys_pg = 1'b0;
    pwrseq_pkg::avs_req_t avs_req = '0;
    pwrseq_pkg::avs_rsp_t avs_rsp;
    pwrseq_pkg::rails_t rails;
    logic sleep_req_n;
    logic softoff_req_n;
    logic keep_en_n;
    logic power_good;
    logic pg_drive;
    logic pg_oe;
    logic uv_arm;
    logic ss_run;
    logic irq;
    logic [31:0] rd;
    int errors = 0;
    int n_tests = 0;

    always #12.5 mclk = ~mclk;

    pwrseq_core pwrseq_core_inst (
        .i_mclk(mclk), .i_srst(srst), .i_sleep_req_n(sleep_req_n),
        .i_softoff_req_n(softoff_req_n), .i_dual5_keep_en_n(keep_en_n),
        .i_power_good(power_good), .i_standby_ok(standby_ok),
        .i_ss_at_limit(ss_at_limit), .i_mem_undervolt(mem_undervolt),
        .i_avs(avs_req), .o_avs(avs_rsp), .o_rails(rails),
        .o_power_good(pg_drive), .o_power_good_oe(pg_oe),
        .o_uv_arm(uv_arm), .o_ss_run(ss_run), .o_irq(irq)
    );

    pmc_model pmc_model_inst (
        .i_mclk(mclk), .i_float(pin_float), .i_sleep_n(sleep_n),
        .i_off_n(off_n), .i_keep_n(keep_n), .i_sys_pg(sys_pg),
        .i_dev_pull(pg_oe), .o_sleep_req_n(sleep_req_n),
        .o_softoff_req_n(softoff_req_n), .o_dual5_keep_en_n(keep_en_n),
        .o_power_good(power_good)
    );

    // ------------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------------
    // Prints the verdict and ends the run
    task automatic give_verdict;
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // Compares one value
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask : step

    // One bus transfer, held until waitrequest is sampled low
    task automatic av_xfer(input logic wr, input logic [3:0] addr,
                           input logic [31:0] wdata);
        int i;
        @(posedge mclk);
        avs_req <= '{read: ~wr, write: wr, address: addr, writedata: wdata};
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (avs_rsp.waitrequest === 1'b0) break;
        end
        rd = avs_rsp.readdata;
        avs_req <= '0;
        if (i == 20) begin
            chk("bus answer", 32'h1, 32'h0);
            give_verdict();
        end
    endtask : av_xfer

    task automatic rd_reg(input logic [3:0] addr);
        av_xfer(1'b0, addr, 32'h0);
    endtask : rd_reg

    task automatic wr_reg(input logic [3:0] addr, input logic [31:0] d);
        av_xfer(1'b1, addr, d);
    endtask : wr_reg

    // Polls the state field under a bound, then compares it
    task automatic wait_state(input pwrseq_pkg::pstate_t s);
        int i;
        for (i = 0; i < 40; i++) begin
            rd_reg(pwrseq_pkg::REG_STATUS);
            if (rd[2:0] === s) break;
        end
        chk("state", s, rd[2:0]);
        if (i == 40) give_verdict();
    endtask : wait_state

    // Ramping move: held until the ramp limit is reached
    task automatic ramp_to(input pwrseq_pkg::pstate_t from,
                           input pwrseq_pkg::pstate_t to);
        step(8);
        chk("ss_run", 32'h1, ss_run);
        chk("ramp rail", 32'h1, (to == pwrseq_pkg::ST_S0) ? rails.mem_rail
            : rails.dual5_standby_gate);
        rd_reg(pwrseq_pkg::REG_STATUS);
        chk("held state", from, rd[2:0]);
        ss_at_limit <= 1'b1;
        wait_state(to);
        ss_at_limit <= 1'b0;
    endtask : ramp_to

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        step(4);
        srst <= 1'b0;
        step(1);
        // Reset values, registers, unmapped place
        chk("rails", R_G3, rails);
        chk("irq", 32'h0, irq);
        rd_reg(pwrseq_pkg::REG_STATUS);
        chk("g3 state", pwrseq_pkg::ST_G3, rd[2:0]);
        chk("floating pins", 32'h7, rd[18:16]);
        rd_reg(pwrseq_pkg::REG_IRQ_MASK);
        chk("mask reset", 32'h0, rd);
        wr_reg(4'hc, 32'hffffffff);
        rd_reg(4'hc);
        chk("unmapped", 32'h0, rd);
        // Soft-off held, keep off: power-up stops in S5 rail-off
        pin_float <= 1'b0;
        sleep_n <= 1'b1;
        keep_n <= 1'b1;
        step(6);
        standby_ok <= 1'b1;
        wait_state(pwrseq_pkg::ST_S5OFF);
        chk("rails", R_S5OFF, rails);
        chk("uv_arm", 32'h0, uv_arm);
        // Keep enable low: ramp to S5 rail-on
        keep_n <= 1'b0;
        ramp_to(pwrseq_pkg::ST_S5OFF, pwrseq_pkg::ST_S5ON);
        chk("rails", R_S5ON, rails);
        keep_n <= 1'b1;
        wait_state(pwrseq_pkg::ST_S5OFF);
        // Both requests high: ramp to S0
        off_n <= 1'b1;
        ramp_to(pwrseq_pkg::ST_S5OFF, pwrseq_pkg::ST_S0);
        chk("rails", R_S0, rails);
        chk("uv_arm", 32'h1, uv_arm);
        sleep_n <= 1'b0;
        wait_state(pwrseq_pkg::ST_S3);
        chk("rails", R_S3, rails);
        chk("uv_arm", 32'h1, uv_arm);
        // Wake waits for system power good
        sleep_n <= 1'b1;
        step(12);
        rd_reg(pwrseq_pkg::REG_STATUS);
        chk("no wake", pwrseq_pkg::ST_S3, rd[2:0]);
        sys_pg <= 1'b1;
        wait_state(pwrseq_pkg::ST_S0);
        rd_reg(pwrseq_pkg::REG_IRQ_STAT);
        chk("state event", 32'h1, rd[0]);
        // Under-voltage fault with the interrupt path
        wr_reg(pwrseq_pkg::REG_IRQ_STAT, 32'h7);
        wr_reg(pwrseq_pkg::REG_IRQ_MASK, 32'h2);
        step(2);
        chk("irq", 32'h0, irq);
        mem_undervolt <= 1'b1;
        for (int i = 0; i < 20 && pg_oe !== 1'b1; i++) step(1);
        mem_undervolt <= 1'b0;
        chk("pg pull", 32'h1, pg_oe);
        chk("pg wire", 32'h0, power_good);
        chk("pg drive", 32'h0, pg_drive);
        step(2);
        chk("irq", 32'h1, irq);
        rd_reg(pwrseq_pkg::REG_STATUS);
        chk("fault bit", 32'h1, rd[7]);
        wr_reg(pwrseq_pkg::REG_IRQ_MASK, 32'h0);
        step(2);
        chk("irq masked", 32'h0, irq);
        wr_reg(pwrseq_pkg::REG_IRQ_MASK, 32'h2);
        step(2);
        chk("irq unmasked", 32'h1, irq);
        wr_reg(pwrseq_pkg::REG_IRQ_STAT, 32'h2);
        step(2);
        chk("irq cleared", 32'h0, irq);
        rd_reg(pwrseq_pkg::REG_IRQ_STAT);
        chk("fault event", 32'h0, rd[1]);
        // Soft-off with keep low picks S5 rail-on at once
        keep_n <= 1'b0;
        off_n <= 1'b0;
        wait_state(pwrseq_pkg::ST_S5ON);
        chk("rails", R_S5ON, rails);
        chk("pg pull", 32'h0, pg_oe);
        chk("uv_arm", 32'h0, uv_arm);
        // Wake from S5 rail-on ramps mem and term rails into S0
        off_n <= 1'b1;
        ramp_to(pwrseq_pkg::ST_S5ON, pwrseq_pkg::ST_S0);
        chk("rails", R_S0, rails);
        // Soft-off from S3 with keep high picks S5 rail-off
        sleep_n <= 1'b0;
        wait_state(pwrseq_pkg::ST_S3);
        keep_n <= 1'b1;
        off_n <= 1'b0;
        wait_state(pwrseq_pkg::ST_S5OFF);
        chk("rails", R_S5OFF, rails);
        // Standby loss returns to G3
        standby_ok <= 1'b0;
        wait_state(pwrseq_pkg::ST_G3);
        chk("rails", R_G3, rails);
        give_verdict();
    end
endmodule : pwrseq_core_bench
